// [bus_node_model.sv]
/*
 Other nodes on the bus: sends frames into the block and answers its
 transmissions, promptly or after lag cycles. Assumes the bench sets
 lag and reply and calls send_frame right after a clock edge.
*/
`timescale 1ns/1ns
module bus_node_model (
   input  wire        sys_clk,            // Clock
   input  wire        tx_req,             // Block owns a transmission
   input  wire [3:0]  tx_ch,              // Channel sent
   input  wire [3:0]  tx_cmd,             // Command sent
   input  wire [4:0]  tx_len,             // Bytes to send
   input  wire [7:0]  tx_byte,            // Current byte
   output reg         rx_start,           // Header pulse
   output reg  [11:0] rx_id,              // Identifier
   output reg  [3:0]  rx_cmd,             // {ext,ack,rnw,rtr}
   output reg         reply_start,        // In-frame reply pulse
   output reg         rx_byte_valid,      // Byte strobe
   output reg  [7:0]  rx_byte,            // Data byte
   output reg         rx_ok,              // Good frame pulse
   output reg         rx_err,             // Error pulse, never raised
   output reg         tx_byte_next,       // Advance byte
   output reg         tx_done             // Frame sent
);
   integer     lag   = 0;                 // Cycles before answering
   reg         reply = 1'b0;              // Answer reply requests in frame
   reg  [11:0] log_q [$];                 // {channel, first byte} per transmission

   // Idle levels at time zero
   initial begin
      {rx_start, rx_id, rx_cmd, reply_start, rx_byte_valid, rx_byte} = 0;
      {rx_ok, rx_err, tx_byte_next, tx_done} = 0;
   end

   // Bytes counting up from b, then one good end pulse
   task automatic send_bytes(input integer n, input [7:0] b);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            rx_byte_valid <= 1'b1;
            rx_byte       <= b + k[7:0];
            @(posedge sys_clk);
         end
         rx_byte_valid <= 1'b0;
         rx_byte       <= ~(b + n[7:0]);  // Released line shows no stale byte
         rx_ok         <= 1'b1;
         @(posedge sys_clk);
         rx_ok <= 1'b0;
      end
   endtask

   // Header with its identifier and command, then the data field
   task automatic send_frame(input [11:0] id, input [3:0] cmd, input integer n,
                             input [7:0] b);
      begin
         rx_start <= 1'b1;
         rx_id    <= id;
         rx_cmd   <= cmd;
         @(posedge sys_clk);
         rx_start <= 1'b0;
         send_bytes(n, b);
      end
   endtask

   // Answer each transmission; replies only while the block owns the bus
   initial forever begin
      @(posedge sys_clk);
      if (tx_req) begin
         log_q.push_back({tx_ch, tx_byte});
         repeat (lag) @(posedge sys_clk);
         if (reply && tx_cmd[1:0] == 2'b11) begin
            reply_start <= 1'b1;          // Another node replies in frame
            @(posedge sys_clk);
            reply_start <= 1'b0;
            send_bytes(2, 8'hA0);
         end else begin
            repeat (tx_len) begin
               tx_byte_next <= 1'b1;
               @(posedge sys_clk);
               tx_byte_next <= 1'b0;
               @(posedge sys_clk);
            end
            tx_done <= 1'b1;              // Frame went out error-free
            @(posedge sys_clk);
            tx_done <= 1'b0;
         end
         @(posedge sys_clk);
      end
   end
endmodule

// [channel_message_type_engine.v]
/*
 Channel message type engine: channel register sets, 128-byte mailbox,
 receive match and store, transmit selection and flag updates.
 Assumes the line logic runs on sys_clk and reports frame events as
 one-cycle pulses, and that software uses the plain register port.
*/
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "channel_message_type_engine_map.vh"
module channel_message_type_engine #(
   parameter NUM_CH = 14                  // Number of channel sets
) (
   input  wire        sys_clk,            // Clock, 100 MHz
   input  wire        reset,              // Sync reset, high
   input  wire [7:0]  bus_addr,           // Register address
   input  wire [7:0]  bus_wdata,          // Write data
   input  wire        bus_wr,             // Write strobe
   input  wire        bus_rd,             // Read strobe
   output reg  [7:0]  bus_rdata,          // Read data, next cycle
   input  wire        rx_start,           // Header received pulse
   input  wire [11:0] rx_id,              // Received identifier
   input  wire        rx_ext,             // Received extension bit
   input  wire        rx_ack,             // Received ack request bit
   input  wire        rx_rnw,             // Received direction bit
   input  wire        rx_rtr,             // Received reply request bit
   input  wire        reply_start,        // In-frame reply begins
   input  wire        rx_byte_valid,      // Data byte strobe
   input  wire [7:0]  rx_byte,            // Data byte
   input  wire        rx_ok,              // Receive complete pulse
   input  wire        rx_err,             // Receive error pulse
   output reg         rx_full,            // Reserved length reached
   output reg         tx_req,             // Transmission pending
   output reg  [3:0]  tx_ch,              // Channel being sent
   output reg  [3:0]  tx_cmd,             // Command bits to send
   output reg  [11:0] tx_id,              // Identifier to send
   output reg         tx_inframe,         // Sending an in-frame reply
   output reg  [4:0]  tx_len,             // Data bytes to send
   output reg  [7:0]  tx_byte,            // Current data byte
   input  wire        tx_byte_next,       // Advance to next byte
   input  wire        tx_done             // Sent or retries exceeded
);

   // One-hot state codes
   localparam [1:0] T_IDLE = 2'b01;
   localparam [1:0] T_BUSY = 2'b10;
   localparam [1:0] R_IDLE = 2'b01;
   localparam [1:0] R_RECV = 2'b10;
   localparam [3:0] NCH    = NUM_CH[3:0];

   // Channel register sets
   reg  [11:0] id_reg   [0:NUM_CH-1];     // Identifier tag
   reg  [3:0]  cmd_reg  [0:NUM_CH-1];     // Ext, ack, rnw, rtr
   reg  [7:0]  ptr_reg  [0:NUM_CH-1];     // Spy bit and pointer
   reg  [4:0]  len_reg  [0:NUM_CH-1];     // Reserved length
   reg         err_reg  [0:NUM_CH-1];     // Channel error
   reg         txf_reg  [0:NUM_CH-1];     // Transmitted flag
   reg         rxf_reg  [0:NUM_CH-1];     // Received flag
   reg  [11:0] msk_reg  [0:NUM_CH-1];     // Identifier mask
   reg  [7:0]  mbox     [0:127];          // Mailbox storage

   // Engine state
   reg  [1:0]  t_state_reg;               // Transmit state
   reg  [1:0]  r_state_reg;               // Receive state
   reg  [3:0]  r_ch_reg;                  // Receive target channel
   reg         r_inf_reg;                 // Target is in-frame reply
   reg  [5:0]  r_cnt_reg;                 // Bytes seen incl. checksum
   reg  [2:0]  r_cmd_reg;                 // Captured command bits
   reg  [11:0] r_id_reg;                  // Captured identifier
   reg  [6:0]  t_ptr_reg;                 // Next byte to fetch

   // Decode results
   reg         hit_v;                     // Some channel matches
   reg  [3:0]  hit_c;                     // Lowest matching channel
   reg         pick_v;                    // Some channel ready
   reg  [3:0]  pick_c;                    // Lowest ready channel
   reg  [7:0]  rd_val;                    // Read mux value
   reg  [4:0]  cap;                       // Data room of target
   integer     i;                         // Loop index
   integer     j;                         // Reset index

   // Offset inside the channel area
   wire [7:0]  boff   = bus_addr - `CH_BASE;
   wire [3:0]  bch    = boff[6:3];
   wire        bch_ok = !bus_addr[7] && (bus_addr >= `CH_BASE) && (bch < NCH);

   // Masked identifier compare
   function id_match;
      input [11:0] a;
      input [11:0] b;
      input [11:0] m;
      begin
         id_match = ((a ^ b) & m) == 12'h000;
      end
   endfunction

   // Mailbox offset plus step, wrapping in the area
   function [6:0] wrap;
      input [6:0] base;
      input [5:0] step;
      reg   [7:0] s;
      begin
         s    = {1'b0, base} + {2'b00, step};
         wrap = s[6:0];
      end
   endfunction

   // Lowest-numbered match and lowest-numbered ready channel
   always @* begin
      hit_v  = 1'b0;
      hit_c  = 4'h0;
      pick_v = 1'b0;
      pick_c = 4'h0;
      for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
         // Length zero channels are not served here
         if (len_reg[i] != 5'h00) begin
            // Store types take data or deferred replies
            if (!rx_rtr && cmd_reg[i][`CMD_RTR] && !rxf_reg[i] &&
                id_match(rx_id, id_reg[i], msk_reg[i]) &&
                rx_ext == cmd_reg[i][`CMD_EXT]) begin
               hit_v = 1'b1;
               hit_c = i[3:0];
            end
            // Reply types take reply request frames
            if (rx_rtr && cmd_reg[i][`CMD_RNW] && !cmd_reg[i][`CMD_RTR] &&
                !rxf_reg[i] && id_match(rx_id, id_reg[i], msk_reg[i]) &&
                rx_ext == cmd_reg[i][`CMD_EXT]) begin
               hit_v = 1'b1;
               hit_c = i[3:0];
            end
            // Transmit candidates, flags both set stay out
            if (!txf_reg[i] && (
                (!cmd_reg[i][`CMD_RNW] && !cmd_reg[i][`CMD_RTR]) ||
                (cmd_reg[i][`CMD_RNW] && cmd_reg[i][`CMD_RTR]) ||
                (cmd_reg[i][`CMD_RNW] && rxf_reg[i]))) begin
               pick_v = 1'b1;
               pick_c = i[3:0];
            end
         end
      end
   end

   // Room for data in the receive target
   always @* begin
      cap = len_reg[r_ch_reg] - 5'h01;
   end

   // Register read mux
   always @* begin
      rd_val = `RST_BYTE;
      if (bus_addr[7]) begin
         rd_val = mbox[bus_addr[6:0]];
      end else if (bch_ok) begin
         case (bus_addr[2:0])
            `OFF_ID_HI:  rd_val = id_reg[bch][11:4];
            `OFF_CMD:    rd_val = {id_reg[bch][3:0], cmd_reg[bch]};
            `OFF_PTR:    rd_val = ptr_reg[bch];
            `OFF_LEN:    rd_val = {len_reg[bch], err_reg[bch],
                                   txf_reg[bch], rxf_reg[bch]};
            `OFF_MSK_HI: rd_val = msk_reg[bch][11:4];
            `OFF_MSK_LO: rd_val = {msk_reg[bch][3:0], 4'h0};
            default:     rd_val = `RST_BYTE;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge sys_clk) begin
      if (reset) begin
         bus_rdata <= `RST_BYTE;
      end else begin
         bus_rdata <= bus_rd ? rd_val : `RST_BYTE;
      end
   end

   // Mailbox: software writes first, engine writes win
   always @(posedge sys_clk) begin
      if (bus_wr && bus_addr[7]) begin
         mbox[bus_addr[6:0]] <= bus_wdata;
      end
      // Store data bytes while room remains
      if (r_state_reg == R_RECV && rx_byte_valid &&
          r_cnt_reg < {1'b0, cap}) begin
         mbox[wrap(ptr_reg[r_ch_reg][6:0], r_cnt_reg + 6'h01)] <= rx_byte;
      end
      // Status byte only on a good frame
      if (r_state_reg == R_RECV && rx_ok) begin
         mbox[ptr_reg[r_ch_reg][6:0]] <=
            {r_cmd_reg, (r_cnt_reg > 6'h20) ? 5'h1F :
             (r_cnt_reg < 6'h02) ? 5'h01 : r_cnt_reg[4:0] - 5'h01};
      end
   end

   // Channel registers, receive and transmit engine
   always @(posedge sys_clk) begin
      if (reset) begin
         for (j = 0; j < NUM_CH; j = j + 1) begin
            id_reg[j]  <= `RST_ID;
            cmd_reg[j] <= `RST_CMD;
            ptr_reg[j] <= `RST_BYTE;
            len_reg[j] <= `RST_LEN;
            err_reg[j] <= 1'b0;
            txf_reg[j] <= `RST_FLAGS;
            rxf_reg[j] <= `RST_FLAGS;
            msk_reg[j] <= `RST_ID;
         end
         t_state_reg <= T_IDLE;
         r_state_reg <= R_IDLE;
         r_ch_reg    <= 4'h0;
         r_inf_reg   <= 1'b0;
         r_cnt_reg   <= 6'h00;
         r_cmd_reg   <= 3'h0;
         r_id_reg    <= `RST_ID;
         t_ptr_reg   <= 7'h00;
         rx_full     <= 1'b0;
         tx_req      <= 1'b0;
         tx_ch       <= 4'h0;
         tx_cmd      <= 4'h0;
         tx_id       <= `RST_ID;
         tx_inframe  <= 1'b0;
         tx_len      <= 5'h00;
         tx_byte     <= `RST_BYTE;
      end else begin
         // Software writes; hardware sets below override
         if (bus_wr && bch_ok) begin
            case (bus_addr[2:0])
               `OFF_ID_HI: id_reg[bch][11:4] <= bus_wdata;
               `OFF_CMD: begin
                  id_reg[bch][3:0] <= bus_wdata[7:4];
                  cmd_reg[bch]     <= bus_wdata[3:0];
               end
               `OFF_PTR: ptr_reg[bch] <= bus_wdata;
               `OFF_LEN: begin
                  len_reg[bch] <= bus_wdata[7:3];
                  err_reg[bch] <= bus_wdata[2];
                  txf_reg[bch] <= bus_wdata[1];
                  rxf_reg[bch] <= bus_wdata[0];
               end
               `OFF_MSK_HI: msk_reg[bch][11:4] <= bus_wdata;
               `OFF_MSK_LO: msk_reg[bch][3:0]  <= bus_wdata[7:4];
               default: ;
            endcase
         end

         // Header of a new frame: pick the lowest matching channel
         if (rx_start) begin
            r_state_reg <= R_IDLE;
            rx_full     <= 1'b0;
            if (hit_v && !rx_rtr) begin
               r_state_reg <= R_RECV;
               r_ch_reg    <= hit_c;
               r_inf_reg   <= 1'b0;
               r_cnt_reg   <= 6'h00;
               r_cmd_reg   <= {rx_ack, rx_rnw, rx_rtr};
               r_id_reg    <= rx_id;
            end else if (hit_v && txf_reg[hit_c]) begin
               r_state_reg <= R_RECV;
               r_ch_reg    <= hit_c;
               r_inf_reg   <= 1'b0;
               r_cnt_reg   <= 6'h00;
               r_cmd_reg   <= {rx_ack, rx_rnw, rx_rtr};
               r_id_reg    <= rx_id;
            end else if (hit_v) begin
               // Immediate reply: answer inside this frame
               t_state_reg <= T_BUSY;
               tx_req      <= 1'b1;
               tx_inframe  <= 1'b1;
               tx_ch       <= hit_c;
               tx_cmd      <= cmd_reg[hit_c];
               tx_id       <= id_reg[hit_c];
               tx_len      <= len_reg[hit_c] - 5'h01;
               tx_byte     <= mbox[wrap(ptr_reg[hit_c][6:0], 6'h01)];
               t_ptr_reg   <= wrap(ptr_reg[hit_c][6:0], 6'h02);
            end
         end

         // In-frame reply to our own request, unless buffer occupied
         if (reply_start && t_state_reg == T_BUSY &&
             tx_cmd[`CMD_RNW] && tx_cmd[`CMD_RTR] && !rxf_reg[tx_ch]) begin
            r_state_reg <= R_RECV;
            r_ch_reg    <= tx_ch;
            r_inf_reg   <= 1'b1;
            r_cnt_reg   <= 6'h00;
            r_cmd_reg   <= {tx_cmd[`CMD_ACK], tx_cmd[`CMD_RNW], tx_cmd[`CMD_RTR]};
            rx_full     <= 1'b0;
         end

         // Data bytes: count, flag the reserved length
         if (r_state_reg == R_RECV && rx_byte_valid) begin
            if (r_cnt_reg != 6'h3F) begin
               r_cnt_reg <= r_cnt_reg + 6'h01;
            end
            if (r_cnt_reg + 6'h01 >= {1'b0, cap}) begin
               rx_full <= 1'b1;
            end
         end

         // Good frame: set received; rewrite identifier, or set transmitted if in-frame
         if (r_state_reg == R_RECV && rx_ok) begin
            r_state_reg <= R_IDLE;
            rx_full     <= 1'b0;
            rxf_reg[r_ch_reg] <= 1'b1;
            if (r_inf_reg) begin
               txf_reg[r_ch_reg] <= 1'b1;
               t_state_reg <= T_IDLE;
               tx_req      <= 1'b0;
            end else begin
               id_reg[r_ch_reg] <= r_id_reg;
            end
         end

         // Bad frame: flags untouched, error noted
         if (r_state_reg == R_RECV && rx_err) begin
            r_state_reg <= R_IDLE;
            rx_full     <= 1'b0;
            err_reg[r_ch_reg] <= 1'b1;
         end

         // Start the lowest ready channel when idle
         if (t_state_reg == T_IDLE && !rx_start && pick_v) begin
            t_state_reg <= T_BUSY;
            tx_req      <= 1'b1;
            tx_inframe  <= 1'b0;
            tx_ch       <= pick_c;
            tx_cmd      <= cmd_reg[pick_c];
            tx_id       <= id_reg[pick_c];
            // Reply request frames carry no data of their own
            tx_len      <= (cmd_reg[pick_c][`CMD_RNW] && cmd_reg[pick_c][`CMD_RTR])
                           ? 5'h00 : len_reg[pick_c] - 5'h01;
            tx_byte     <= mbox[wrap(ptr_reg[pick_c][6:0], 6'h01)];
            t_ptr_reg   <= wrap(ptr_reg[pick_c][6:0], 6'h02);
         end

         // Next byte for the line
         if (t_state_reg == T_BUSY && tx_byte_next) begin
            tx_byte   <= mbox[t_ptr_reg];
            t_ptr_reg <= wrap(t_ptr_reg, 6'h01);
         end

         // Transmission finished or retries exhausted
         if (t_state_reg == T_BUSY && tx_done) begin
            t_state_reg <= T_IDLE;
            tx_req      <= 1'b0;
            txf_reg[tx_ch] <= 1'b1;
            if (tx_inframe) begin
               rxf_reg[tx_ch] <= 1'b1;
            end
         end
      end
   end

endmodule

// [channel_message_type_engine_chk.sv]
/*
 Checker for the channel message type engine: port-level relations of
 the transmit and receive handshakes. Assumes sys_clk and a synchronous
 active-high reset, and is bound to the top module.
*/
`timescale 1ns/1ns
module channel_message_type_engine_chk #(
   parameter NUM_CH = 14                  // Number of channel sets
) (
   input wire        sys_clk,             // Clock
   input wire        reset,               // Sync reset, high
   input wire        bus_rd,              // Read strobe
   input wire [7:0]  bus_rdata,           // Read data
   input wire        rx_start,            // Header pulse
   input wire        rx_byte_valid,       // Byte strobe
   input wire        rx_ok,               // Good frame pulse
   input wire        rx_full,             // Reserved room reached
   input wire        tx_req,              // Transmission owned
   input wire [3:0]  tx_ch,               // Channel sent
   input wire [3:0]  tx_cmd,              // Command sent
   input wire [11:0] tx_id,               // Identifier sent
   input wire        tx_inframe,          // In-frame reply
   input wire [4:0]  tx_len,              // Bytes to send
   input wire        tx_done              // Frame finished
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // A new transmission, and the end of one
   sequence s_pick; !tx_req ##1 tx_req; endsequence
   sequence s_end;  tx_req && tx_done; endsequence

   property p_pick_ch; s_pick |-> tx_ch < NUM_CH; endproperty
   a_pick_ch: assert property (p_pick_ch) else $error("tx channel out of range");
   property p_end; s_end |=> !tx_req; endproperty
   a_end: assert property (p_end) else $error("tx_req stays after tx_done");
   property p_hold;
      tx_req && !tx_done && !rx_ok |=> tx_req && $stable(tx_ch) && $stable(tx_id);
   endproperty
   a_hold: assert property (p_hold) else $error("transmission changed midway");
   property p_no_rx_tx; tx_req |-> tx_cmd[1:0] != 2'b01; endproperty
   a_no_rx_tx: assert property (p_no_rx_tx) else $error("receive type sent");
   property p_rr_len; tx_req && tx_cmd[1:0] == 2'b11 |-> tx_len == 5'h00; endproperty
   a_rr_len: assert property (p_rr_len) else $error("reply request has data");
   property p_inframe; tx_req && tx_inframe |-> tx_cmd[1:0] == 2'b10; endproperty
   a_inframe: assert property (p_inframe) else $error("in-frame reply of wrong type");
   property p_full_clr; rx_start || rx_ok |-> ##1 !rx_full; endproperty
   a_full_clr: assert property (p_full_clr) else $error("rx_full not cleared");
   property p_full_hold; !rx_full && !rx_byte_valid |=> !rx_full; endproperty
   a_full_hold: assert property (p_full_hold) else $error("rx_full without a byte");
   property p_rd_idle; !bus_rd |=> bus_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
endmodule

bind channel_message_type_engine channel_message_type_engine_chk #(.NUM_CH(NUM_CH)) i_chk (
   .sys_clk, .reset, .bus_rd, .bus_rdata, .rx_start, .rx_byte_valid, .rx_ok, .rx_full,
   .tx_req, .tx_ch, .tx_cmd, .tx_id, .tx_inframe, .tx_len, .tx_done);

// [channel_message_type_engine_map.vh]
/*
 Constants for the channel message type engine: register offsets, field
 positions and reset values. Assumes an 8-bit register space with the
 mailbox in its upper half and the channel sets below it.
*/
// What this block does
// - Copy received command bits into status byte
// - Received length is data bytes plus one
// - Status byte written only on good reception
// - Data starts one byte after pointer
// - Spare room also stores the two checksum bytes
// - Data ends at reserved length or end mark
// - Mailbox addressing wraps inside its area
// - Data frame sent, then transmitted flag set
// - Receive type never sends, stores, sets received
// - Matched frame stored, length in first byte
// - Received identifier overwrites channel identifier
// - Reply request sent, then waits deferred reply
// - In-frame reply sets both flags at once
// - Transmitted reply request only waits for reply
// - Immediate reply sent, both flags then set
// - Deferred reply sent at once, transmitted set
// - Reply request detected, received flag set
// - Completed or both-set channels are inactive
// - Illegal type sends request, refuses reply
// - Lowest matching channel takes received frame
// - Lowest ready channel transmits first
// - Identifier bits compared only where mask set
// - Hardware sets flags, software writes may set or clear them
`ifndef CHANNEL_MESSAGE_TYPE_ENGINE_MAP_VH
`define CHANNEL_MESSAGE_TYPE_ENGINE_MAP_VH
`define CH_BASE     8'h10
`define MBOX_BASE   8'h80
`define OFF_ID_HI   3'h0
`define OFF_CMD     3'h1
`define OFF_PTR     3'h2
`define OFF_LEN     3'h3
`define OFF_MSK_HI  3'h6
`define OFF_MSK_LO  3'h7
`define CMD_EXT     3
`define CMD_ACK     2
`define CMD_RNW     1
`define CMD_RTR     0
`define ST_ACK      7
`define ST_RNW      6
`define ST_RTR      5
`define RST_BYTE    8'h00
`define RST_ID      12'h000
`define RST_CMD     4'h0
`define RST_LEN     5'h00
`define RST_FLAGS   1'b1
`endif

// [channel_message_type_engine_tb.sv]
/*
 Bench for the channel message type engine: register rows, shared
 reception, transmit order and an in-frame reply. Assumes the node
 model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
module channel_message_type_engine_tb;
   reg         sys_clk   = 1'b0;          // 100 MHz clock
   reg         reset     = 1'b1;          // Sync reset, high
   reg  [7:0]  bus_addr  = 8'h00;         // Register address
   reg  [7:0]  bus_wdata = 8'h00;         // Write data
   reg         bus_wr    = 1'b0;          // Write strobe
   reg         bus_rd    = 1'b0;          // Read strobe
   wire [7:0]  bus_rdata;                 // Read data
   wire        rx_start, reply_start, rx_byte_valid, rx_ok, rx_err; // Node pulses
   wire        rx_full, tx_req, tx_inframe, tx_byte_next, tx_done; // Handshake
   wire [3:0]  rx_cmd, tx_ch, tx_cmd;     // Commands and channel
   wire [11:0] rx_id, tx_id;              // Identifiers
   wire [7:0]  rx_byte, tx_byte;          // Data bytes
   wire [4:0]  tx_len;                    // Bytes to send
   integer     err_count = 0;             // Mismatches
   integer     checks    = 0;             // Comparisons
   integer     i;                         // Loop index
   reg  [7:0]  b;                         // Channel base
   reg  [23:0] rows [0:5] = '{24'h10ABAB, 24'h115C5C, 24'h17FFF0, 24'h147700,
                              24'h051200, 24'hC05A5A}; // {addr, wdata, expected}
   reg  [15:0] rxe [0:9] = '{16'hFE82, 16'hFF11, 16'h8012, 16'h8113, 16'h19C1,
                             16'h1B21, 16'h9082, 16'h9111, 16'h21C1, 16'h2321}; // {addr, exp}

   // Clock
   initial forever #5 sys_clk = ~sys_clk;

   channel_message_type_engine i_channel_message_type_engine (
      .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_start(rx_start),
      .rx_id(rx_id), .rx_ext(rx_cmd[3]), .rx_ack(rx_cmd[2]), .rx_rnw(rx_cmd[1]),
      .rx_rtr(rx_cmd[0]), .reply_start(reply_start), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_ok(rx_ok), .rx_err(rx_err), .rx_full(rx_full),
      .tx_req(tx_req), .tx_ch(tx_ch), .tx_cmd(tx_cmd), .tx_id(tx_id),
      .tx_inframe(tx_inframe), .tx_len(tx_len), .tx_byte(tx_byte),
      .tx_byte_next(tx_byte_next), .tx_done(tx_done));
   bus_node_model i_node (
      .sys_clk(sys_clk), .tx_req(tx_req), .tx_ch(tx_ch), .tx_cmd(tx_cmd),
      .tx_len(tx_len), .tx_byte(tx_byte), .rx_start(rx_start), .rx_id(rx_id),
      .rx_cmd(rx_cmd), .reply_start(reply_start), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_ok(rx_ok), .rx_err(rx_err),
      .tx_byte_next(tx_byte_next), .tx_done(tx_done));

   // Compare and count
   task chk(input string name, input [11:0] exp, input [11:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // Write cycle then an idle cycle
   task wr(input [7:0] a, input [7:0] d);
      begin
         bus_addr  <= a;
         bus_wdata <= d;
         bus_wr    <= 1'b1;
         @(posedge sys_clk);
         bus_wr <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   // Read cycle; data sampled mid-cycle after it
   task rdc(input [7:0] a, input [7:0] exp);
      begin
         bus_addr <= a;
         bus_rd   <= 1'b1;
         @(posedge sys_clk);
         bus_rd <= 1'b0;
         @(negedge sys_clk);
         chk($sformatf("addr %h", a), {4'h0, exp}, {4'h0, bus_rdata});
         @(posedge sys_clk);
      end
   endtask
   // Bounded wait for n logged, finished transmissions
   task wait_tx(input integer n);
      for (i = 0; i < 500 && (i_node.log_q.size() < n || tx_req); i = i + 1)
         @(posedge sys_clk);
   endtask
   // Counts, verdict, end of run
   task results;
      begin
         $display("Counts: %0d checks, %0d mismatches", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   // Watchdog
   initial begin
      #100000;
      err_count = err_count + 1;
      $display("Error watchdog expired");
      results;
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rdc(8'h13, 8'h03);
      for (i = 0; i < 6; i = i + 1) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0]);
      end
      $display("Test registers done");
      // Two receive channels, id 0xA5x, low nibble masked
      for (b = 8'h18; b < 8'h28; b = b + 8'h08) begin
         wr(b, 8'hA5);
         wr(b + 8'h01, 8'h31);
         wr(b + 8'h02, b == 8'h18 ? 8'h7E : 8'h10);
         wr(b + 8'h06, 8'hFF);
         wr(b + 8'h03, 8'h20);
      end
      i_node.send_frame(12'hA5C, 4'h4, 3, 8'h11);
      i_node.send_frame(12'hA5C, 4'h4, 3, 8'h11);
      for (i = 0; i < 10; i = i + 1)
         rdc(rxe[i][15:8], rxe[i][7:0]);
      chk("tx count", 12'h000, i_node.log_q.size());
      $display("Test reception done");
      // Channel 5 sends slowly, 4 then 3 armed behind it
      i_node.lag = 20;
      wr(8'h38, 8'h55);
      wr(8'h3A, 8'h20);
      wr(8'hA1, 8'hEE);
      wr(8'h3B, 8'h18);
      wr(8'h31, 8'h40);
      wr(8'h33, 8'h10);
      wr(8'h29, 8'h30);
      wr(8'h2B, 8'h10);
      wait_tx(3);
      chk("first tx", 12'h5EE, i_node.log_q[0]);
      chk("second tx", 12'h313, i_node.log_q[1]);
      chk("third tx", 12'h413, i_node.log_q[2]);
      rdc(8'h3B, 8'h1A);
      rdc(8'h2B, 8'h12);
      rdc(8'h33, 8'h12);
      $display("Test transmit order done");
      // Reply request answered in frame by another node
      i_node.lag   = 0;
      i_node.reply = 1'b1;
      wr(8'h41, 8'h03);
      wr(8'h42, 8'h40);
      wr(8'h43, 8'h20);
      wait_tx(4);
      rdc(8'h43, 8'h23);
      rdc(8'hC1, 8'hA0);
      wr(8'h49, 8'h02);
      wr(8'h4B, 8'h10);
      i_node.send_frame(12'h000, 4'h1, 0, 8'h00);
      wait_tx(5);
      rdc(8'h4B, 8'h13);
      $display("Test in-frame reply done");
      results;
   end
endmodule
